// ===== shared/ers_pkg.sv
// Package with offsets, field positions and codes of the error record status block.
package ers_pkg;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Register offsets of the record.
	localparam logic [7:0] ERS_OFF_STATUS = 8'h10;
	localparam logic [7:0] ERS_OFF_MISC0  = 8'h20;
	localparam logic [7:0] ERS_OFF_MISC1  = 8'h28;
	localparam logic [7:0] ERS_OFF_MISC2  = 8'h30;
	localparam logic [7:0] ERS_OFF_MISC3  = 8'h38;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Field positions of the status register.
	localparam int ERS_B_VALID    = 30;
	localparam int ERS_B_UNCORR   = 29;
	localparam int ERS_B_OVF      = 27;
	localparam int ERS_B_MISCV    = 26;
	localparam int ERS_B_CORR_HI  = 25;
	localparam int ERS_B_CORR_LO  = 24;
	localparam int ERS_B_DEFER    = 23;
	localparam int ERS_B_POISON   = 22;
	localparam int ERS_B_CRIT     = 19;
	localparam int ERS_B_EXT_LO   = 8;
	localparam int ERS_B_PRIM_LO  = 0;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Field positions of the first miscellaneous register.
	localparam int ERS_B_OVF_OTHER  = 47;
	localparam int ERS_B_CNT_OTHER  = 40;
	localparam int ERS_B_OVF_REPEAT = 39;
	localparam int ERS_B_CNT_REPEAT = 32;
	localparam int ERS_B_WAY_LO     = 28;
	localparam int ERS_B_INDEX_LO   = 6;
	localparam int ERS_B_LEVEL_LO   = 1;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Widths and codes.
	localparam int ERS_CNT_W   = 7;
	localparam int ERS_INDEX_W = 18;
	localparam int ERS_WAY_W   = 4;
	localparam int ERS_CODE_W  = 8;
	localparam logic [1:0] ERS_CORR_NONE = 2'h0;
	localparam logic [1:0] ERS_CORR_SEEN = 2'h2;
	localparam logic [7:0] ERS_PRIM_NONE   = 8'h00;
	localparam logic [7:0] ERS_PRIM_IMPDEF = 8'h01;
	localparam logic [7:0] ERS_PRIM_ASSOC_CTRL = 8'h07;
	localparam logic [7:0] ERS_PRIM_LAST   = 8'h15;
	localparam logic [7:0] ERS_EXT_TAG_RAM = 8'h00;
	localparam logic [7:0] ERS_EXT_SNOOP_RAM = 8'h02;
	localparam logic [2:0] ERS_LEVEL_THIRD = 3'h2;
	localparam logic [63:0] ERS_ZERO64 = 64'h0;

	// Kind of error offered by the detection logic.
	typedef enum logic [1:0] {
		ERS_KIND_CORRECTED,
		ERS_KIND_DEFERRED,
		ERS_KIND_UNCORRECTED
	} ers_kind_e;

endpackage : ers_pkg

// ===== core/ers_ce_counter.sv
// Corrected-error counter with a sticky wrap flag, writable by software.
`timescale 1ns/1ps
`default_nettype none

module ers_ce_counter #(
	parameter int CNT_W = ers_pkg::ERS_CNT_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_inc,
	input  wire logic             i_wr,
	input  wire logic [CNT_W-1:0] i_wr_cnt,
	input  wire logic             i_wr_ovf,
	output logic      [CNT_W-1:0] o_cnt,
	output logic                  o_ovf,
	output logic                  o_wrap
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// A count wraps when it is all ones and one more error arrives.
	assign o_wrap = i_inc & (&o_cnt);

	// Count one error per cycle; a hardware increment beats a write in the same cycle.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_cnt <= '0;
		end else if (i_inc) begin
			o_cnt <= o_cnt + CNT_W'(1);
		end else if (i_wr) begin
			o_cnt <= i_wr_cnt;
		end
	end

	// The wrap flag is sticky and a wrap wins over a write that clears it.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_ovf <= 1'b0;
		end else if (o_wrap) begin
			o_ovf <= 1'b1;
		end else if (i_wr) begin
			o_ovf <= i_wr_ovf;
		end
	end

endmodule : ers_ce_counter

`default_nettype wire

// ===== core/ers_status_top.sv
// Error record primary status register with its first miscellaneous syndrome register.
//
// Contract
// - Record-valid bit 30 is set once an error is recorded, zero when empty.
// - Bits 31, 28 and 21:20 read zero and ignore writes.
// - Uncorrected bit 29 set for an error neither corrected nor deferred.
// - Overflow bit 27 set when a counted corrected error wraps the counter.
// - Overflow also set when valid already and a non-corrected error is recorded.
// - Otherwise overflow keeps its value when an error is recorded.
// - Overflow and counter wrap flags may disturb each other on direct writes.
// - Misc-valid bit 26 marks misc register 0; misc 1 to 3 read zero.
// - Corrected field 25:24 reads 00 for none and 10 once corrected.
// - Writing a mixed value to the corrected field may leave any value.
// - Deferred bit 23 set when an error was deferred, not corrected.
// - Poison bit 22 is one for poison, zero for corrupt value, on uncorrected or deferred.
// - Poison bit is meaningless while empty or while neither uncorrected nor deferred.
// - Critical bit 19 set when a critical condition is recorded.
// - All status flags are write-one-to-clear; zeros leave them alone.
// - Type and code fields are meaningless while the record is empty.
// - Extended code 15:8 is 0 tag RAM, 2 snoop RAM, when primary is 7.
// - Primary code 7:0 is the source class; codes above 21 are reserved.
// - Misc-valid qualifies index and way for repeat syndrome matching.
`timescale 1ns/1ps
`default_nettype none

module ers_status_top #(
	parameter int CNT_W   = ers_pkg::ERS_CNT_W,
	parameter int INDEX_W = ers_pkg::ERS_INDEX_W,
	parameter int WAY_W   = ers_pkg::ERS_WAY_W
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	input  wire logic [7:0]             i_reg_addr,
	input  wire logic [63:0]            i_reg_wdata,
	output logic      [63:0]            o_reg_rdata,
	output logic                        o_reg_rvalid,
	input  wire logic                   i_err_valid,
	input  wire ers_pkg::ers_kind_e     i_err_kind,
	input  wire logic                   i_err_poison,
	input  wire logic                   i_err_critical,
	input  wire logic                   i_err_snoop_ram,
	input  wire logic [7:0]             i_err_code,
	input  wire logic [INDEX_W-1:0]     i_err_index,
	input  wire logic [WAY_W-1:0]       i_err_way,
	output logic                        o_record_valid
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Status and syndrome state.
	logic                   valid_flag;
	logic                   uncorrected_flag;
	logic                   overflow_flag;
	logic                   misc_valid_flag;
	logic [1:0]             corrected_field;
	logic                   deferred_flag;
	logic                   poison_flag;
	logic                   critical_flag;
	logic [7:0]             extended_error_code;
	logic [7:0]             primary_error_code;
	logic [INDEX_W-1:0]     cache_index_field;
	logic [WAY_W-1:0]       cache_way_field;
	logic [CNT_W-1:0]       repeat_cnt;
	logic [CNT_W-1:0]       other_cnt;
	logic                   repeat_ovf;
	logic                   other_ovf;
	logic                   repeat_wrap;
	logic                   other_wrap;

	// Decoded events and access strobes.
	logic                   wr_status;
	logic                   wr_misc0;
	logic [63:0]            clr;
	logic                   is_corr;
	logic                   is_urgent;
	logic                   load_syn;
	logic                   syn_match;
	logic                   inc_repeat;
	logic                   inc_other;
	logic [7:0]             next_prim;
	logic [7:0]             next_ext;
	logic [63:0]            status_word;
	logic [63:0]            misc0_word;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Tells whether an access address hits a given register offset.
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
		hits = (addr == off);
	endfunction : hits

	// Maps a source code onto a legal one; reserved codes fold to the generic class.
	function automatic logic [7:0] legal_prim(input logic [7:0] code);
		if (code > ers_pkg::ERS_PRIM_LAST) begin
			legal_prim = ers_pkg::ERS_PRIM_IMPDEF;
		end else if (code == ers_pkg::ERS_PRIM_NONE) begin
			legal_prim = ers_pkg::ERS_PRIM_IMPDEF;
		end else begin
			legal_prim = code;
		end
	endfunction : legal_prim

	////////////////////////////////////////////////////////////////////////////////////////////
	// Register write strobes; a status write is a mask of ones to clear.
	assign wr_status = i_reg_wr & hits(i_reg_addr, ers_pkg::ERS_OFF_STATUS);
	assign wr_misc0  = i_reg_wr & hits(i_reg_addr, ers_pkg::ERS_OFF_MISC0);
	assign clr       = wr_status ? i_reg_wdata : ers_pkg::ERS_ZERO64;

	// Classify the incoming error.
	assign is_corr   = i_err_valid & (i_err_kind == ers_pkg::ERS_KIND_CORRECTED);
	assign is_urgent = i_err_valid & (i_err_kind != ers_pkg::ERS_KIND_CORRECTED);

	// Codes the new error would leave in the record.
	assign next_prim = legal_prim(i_err_code);
	assign next_ext  = (next_prim == ers_pkg::ERS_PRIM_ASSOC_CTRL && i_err_snoop_ram) ?
		ers_pkg::ERS_EXT_SNOOP_RAM : ers_pkg::ERS_EXT_TAG_RAM;

	// An empty record takes any syndrome; one holding no uncorrected or deferred error yields to an urgent one.
	assign load_syn = i_err_valid &
		(!valid_flag | (is_urgent & !uncorrected_flag & !deferred_flag));

	// The repeat syndrome matches only where misc-valid vouches for index and way.
	assign syn_match = misc_valid_flag &
		(extended_error_code == next_ext) &
		(primary_error_code == next_prim) &
		(cache_index_field == i_err_index) &
		(cache_way_field == i_err_way);

	// A corrected error counts as a repeat when it starts the record or matches it.
	assign inc_repeat = is_corr & (!valid_flag | syn_match);
	assign inc_other  = is_corr & !inc_repeat;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Record valid: set by any recorded error, cleared by a one; the set wins.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			valid_flag <= 1'b0;
		end else if (i_err_valid) begin
			valid_flag <= 1'b1;
		end else if (clr[ers_pkg::ERS_B_VALID]) begin
			valid_flag <= 1'b0;
		end
	end

	// Uncorrected flag follows errors that were neither corrected nor deferred.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			uncorrected_flag <= 1'b0;
		end else if (i_err_valid && i_err_kind == ers_pkg::ERS_KIND_UNCORRECTED) begin
			uncorrected_flag <= 1'b1;
		end else if (clr[ers_pkg::ERS_B_UNCORR]) begin
			uncorrected_flag <= 1'b0;
		end
	end

	// Deferred flag follows errors that were deferred instead of corrected.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			deferred_flag <= 1'b0;
		end else if (i_err_valid && i_err_kind == ers_pkg::ERS_KIND_DEFERRED) begin
			deferred_flag <= 1'b1;
		end else if (clr[ers_pkg::ERS_B_DEFER]) begin
			deferred_flag <= 1'b0;
		end
	end

	// Overflow: a counter wrap or an urgent error on an already valid record sets it, else only a written one clears it.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			overflow_flag <= 1'b0;
		end else if (repeat_wrap || other_wrap) begin
			overflow_flag <= 1'b1;
		end else if (is_urgent && valid_flag) begin
			overflow_flag <= 1'b1;
		end else if (clr[ers_pkg::ERS_B_OVF]) begin
			overflow_flag <= 1'b0;
		end
	end

	// Corrected field reads 10 once a corrected error is seen; any one written clears it.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			corrected_field <= ers_pkg::ERS_CORR_NONE;
		end else if (is_corr) begin
			corrected_field <= ers_pkg::ERS_CORR_SEEN;
		end else if (|clr[ers_pkg::ERS_B_CORR_HI:ers_pkg::ERS_B_CORR_LO]) begin
			corrected_field <= ers_pkg::ERS_CORR_NONE;
		end
	end

	// Poison takes the cause of the urgent error whose syndrome is kept.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			poison_flag <= 1'b0;
		end else if (load_syn && is_urgent) begin
			poison_flag <= i_err_poison;
		end else if (clr[ers_pkg::ERS_B_POISON]) begin
			poison_flag <= 1'b0;
		end
	end

	// Critical flag is sticky until software writes a one.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			critical_flag <= 1'b0;
		end else if (i_err_valid && i_err_critical) begin
			critical_flag <= 1'b1;
		end else if (clr[ers_pkg::ERS_B_CRIT]) begin
			critical_flag <= 1'b0;
		end
	end

	// Misc-valid marks that index and way in misc register 0 belong to the record.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			misc_valid_flag <= 1'b0;
		end else if (load_syn) begin
			misc_valid_flag <= 1'b1;
		end else if (clr[ers_pkg::ERS_B_MISCV]) begin
			misc_valid_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Syndrome capture; codes keep their last value after a clear.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			primary_error_code  <= ers_pkg::ERS_PRIM_NONE;
			extended_error_code <= ers_pkg::ERS_EXT_TAG_RAM;
		end else if (load_syn) begin
			primary_error_code  <= next_prim;
			extended_error_code <= next_ext;
		end
	end

	// Location of the kept error; software may also write it.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cache_index_field <= '0;
			cache_way_field   <= '0;
		end else if (load_syn) begin
			cache_index_field <= i_err_index;
			cache_way_field   <= i_err_way;
		end else if (wr_misc0) begin
			cache_index_field <= i_reg_wdata[ers_pkg::ERS_B_INDEX_LO +: INDEX_W];
			cache_way_field   <= i_reg_wdata[ers_pkg::ERS_B_WAY_LO +: WAY_W];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Repeat and other corrected-error counters; at most one count per cycle.
	ers_ce_counter #(
		.CNT_W (CNT_W)
	) u_repeat_cnt (
		.i_clk    (i_clk),
		.i_rst_b  (i_rst_b),
		.i_inc    (inc_repeat),
		.i_wr     (wr_misc0),
		.i_wr_cnt (i_reg_wdata[ers_pkg::ERS_B_CNT_REPEAT +: CNT_W]),
		.i_wr_ovf (i_reg_wdata[ers_pkg::ERS_B_OVF_REPEAT]),
		.o_cnt    (repeat_cnt),
		.o_ovf    (repeat_ovf),
		.o_wrap   (repeat_wrap)
	);

	ers_ce_counter #(
		.CNT_W (CNT_W)
	) u_other_cnt (
		.i_clk    (i_clk),
		.i_rst_b  (i_rst_b),
		.i_inc    (inc_other),
		.i_wr     (wr_misc0),
		.i_wr_cnt (i_reg_wdata[ers_pkg::ERS_B_CNT_OTHER +: CNT_W]),
		.i_wr_ovf (i_reg_wdata[ers_pkg::ERS_B_OVF_OTHER]),
		.o_cnt    (other_cnt),
		.o_ovf    (other_ovf),
		.o_wrap   (other_wrap)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Assemble the read views; unimplemented bits stay zero.
	always_comb begin
		status_word = ers_pkg::ERS_ZERO64;
		status_word[ers_pkg::ERS_B_VALID]  = valid_flag;
		status_word[ers_pkg::ERS_B_UNCORR] = uncorrected_flag;
		status_word[ers_pkg::ERS_B_OVF]    = overflow_flag;
		status_word[ers_pkg::ERS_B_MISCV]  = misc_valid_flag;
		status_word[ers_pkg::ERS_B_CORR_HI:ers_pkg::ERS_B_CORR_LO] = corrected_field;
		status_word[ers_pkg::ERS_B_DEFER]  = deferred_flag;
		status_word[ers_pkg::ERS_B_POISON] = poison_flag;
		status_word[ers_pkg::ERS_B_CRIT]   = critical_flag;
		status_word[ers_pkg::ERS_B_EXT_LO +: ers_pkg::ERS_CODE_W]  = extended_error_code;
		status_word[ers_pkg::ERS_B_PRIM_LO +: ers_pkg::ERS_CODE_W] = primary_error_code;
	end

	// Misc register 0 holds counters, wrap flags, location and fixed level.
	always_comb begin
		misc0_word = ers_pkg::ERS_ZERO64;
		misc0_word[ers_pkg::ERS_B_OVF_OTHER]  = other_ovf;
		misc0_word[ers_pkg::ERS_B_CNT_OTHER +: CNT_W]  = other_cnt;
		misc0_word[ers_pkg::ERS_B_OVF_REPEAT] = repeat_ovf;
		misc0_word[ers_pkg::ERS_B_CNT_REPEAT +: CNT_W] = repeat_cnt;
		misc0_word[ers_pkg::ERS_B_WAY_LO +: WAY_W]     = cache_way_field;
		misc0_word[ers_pkg::ERS_B_INDEX_LO +: INDEX_W] = cache_index_field;
		misc0_word[ers_pkg::ERS_B_LEVEL_LO +: 3]       = ers_pkg::ERS_LEVEL_THIRD;
	end

	// Registered read answer one cycle after the strobe; misc 1 to 3 and holes read zero.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_reg_rdata <= ers_pkg::ERS_ZERO64;
		end else if (i_reg_rd) begin
			if (hits(i_reg_addr, ers_pkg::ERS_OFF_STATUS)) begin
				o_reg_rdata <= status_word;
			end else if (hits(i_reg_addr, ers_pkg::ERS_OFF_MISC0)) begin
				o_reg_rdata <= misc0_word;
			end else begin
				o_reg_rdata <= ers_pkg::ERS_ZERO64;
			end
		end
	end

	// Read strobe echoed as a one-cycle answer marker.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
		end
	end

	// Level view of the record-valid flag for the surrounding logic.
	assign o_record_valid = valid_flag;

endmodule : ers_status_top

`default_nettype wire

// ===== bench/ers_status_assertions.sv
// Concurrent checks on the ports of the error record status block.
`timescale 1ns/1ps
`default_nettype none

module ers_status_checker #(
	parameter int CNT_W   = 7,
	parameter int INDEX_W = 18,
	parameter int WAY_W   = 4
) (
	input wire logic               i_clk,
	input wire logic               i_rst_b,
	input wire logic               i_reg_wr,
	input wire logic               i_reg_rd,
	input wire logic [7:0]         i_reg_addr,
	input wire logic [63:0]        i_reg_wdata,
	input wire logic [63:0]        o_reg_rdata,
	input wire logic               o_reg_rvalid,
	input wire logic               i_err_valid,
	input wire ers_pkg::ers_kind_e i_err_kind,
	input wire logic               i_err_poison,
	input wire logic               i_err_critical,
	input wire logic               i_err_snoop_ram,
	input wire logic [7:0]         i_err_code,
	input wire logic [INDEX_W-1:0] i_err_index,
	input wire logic [WAY_W-1:0]   i_err_way,
	input wire logic               o_record_valid
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	// A software write that clears the record-valid flag.
	wire clr_v = i_reg_wr && i_reg_addr == ers_pkg::ERS_OFF_STATUS && i_reg_wdata[30];

	////////////////////////////////////////////////////////////////
	// Read requests; the status one is followed by its answer.
	sequence s_stat_rd;
		i_reg_rd && i_reg_addr == ers_pkg::ERS_OFF_STATUS ##1 o_reg_rvalid;
	endsequence
	sequence s_spare_rd;
		i_reg_rd && (i_reg_addr == ers_pkg::ERS_OFF_MISC1 ||
			i_reg_addr == ers_pkg::ERS_OFF_MISC2 || i_reg_addr == ers_pkg::ERS_OFF_MISC3);
	endsequence

	////////////////////////////////////////////////////////////////
	// Each read is answered exactly one cycle later, and only then.
	a_rvalid_one: assert property (o_reg_rvalid == $past(i_reg_rd))
		else $error("read answer pulse misplaced");
	a_stat_unused: assert property (s_stat_rd |-> o_reg_rdata[63:31] == 33'h0 &&
		!o_reg_rdata[28] && o_reg_rdata[21:20] == 2'h0 && o_reg_rdata[18:16] == 3'h0)
		else $error("unused status bits not zero");
	a_spare_zero: assert property (s_spare_rd |=> o_reg_rvalid && o_reg_rdata == 64'h0)
		else $error("spare register not zero");
	a_valid_readback: assert property (s_stat_rd |-> o_reg_rdata[30] == $past(o_record_valid))
		else $error("valid bit read differs from flag");
	a_valid_on_err: assert property (i_err_valid |=> o_record_valid)
		else $error("error not recorded as valid");
	a_empty_holds: assert property (!o_record_valid && !i_err_valid |=> !o_record_valid)
		else $error("valid set without an error");
	a_valid_sticky: assert property (o_record_valid && !clr_v |=> o_record_valid)
		else $error("valid lost without a clear");
	a_valid_clear: assert property (clr_v && !i_err_valid |=> !o_record_valid)
		else $error("valid not cleared by write of one");
endmodule : ers_status_checker

bind ers_status_top ers_status_checker #(.CNT_W(CNT_W), .INDEX_W(INDEX_W), .WAY_W(WAY_W)) u_chk (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid), .i_err_valid(i_err_valid), .i_err_kind(i_err_kind),
	.i_err_poison(i_err_poison), .i_err_critical(i_err_critical),
	.i_err_snoop_ram(i_err_snoop_ram), .i_err_code(i_err_code), .i_err_index(i_err_index),
	.i_err_way(i_err_way), .o_record_valid(o_record_valid));
`default_nettype wire

// ===== bench/ers_detector_model.sv
// Model of the cache and snoop filter error detection logic.
`timescale 1ns/1ps
`default_nettype none

module ers_detector_model (
	input  wire logic          i_clk,
	output logic               o_err_valid,
	output ers_pkg::ers_kind_e o_err_kind,
	output logic               o_err_poison,
	output logic               o_err_critical,
	output logic               o_err_snoop_ram,
	output logic [7:0]         o_err_code,
	output logic [17:0]        o_err_index,
	output logic [3:0]         o_err_way
);
	// Idle values at time zero.
	initial begin
		o_err_valid = 1'b0;
		o_err_kind = ers_pkg::ERS_KIND_CORRECTED;
		{o_err_poison, o_err_critical, o_err_snoop_ram} = 3'h0;
		{o_err_code, o_err_index, o_err_way} = 30'h0;
	end

	// Offer one error for one cycle; all fields but the kind turn over afterwards so stale data is useless.
	task automatic raise(input ers_pkg::ers_kind_e k, input logic p, c, s,
		input logic [7:0] code, input logic [17:0] idx, input logic [3:0] way);
		@(posedge i_clk);
		o_err_valid <= 1'b1;
		o_err_kind <= k;
		{o_err_poison, o_err_critical, o_err_snoop_ram} <= {p, c, s};
		{o_err_code, o_err_index, o_err_way} <= {code, idx, way};
		@(posedge i_clk);
		o_err_valid <= 1'b0;
		{o_err_poison, o_err_critical, o_err_snoop_ram} <= ~{p, c, s};
		{o_err_code, o_err_index, o_err_way} <= ~{code, idx, way};
	endtask : raise
endmodule : ers_detector_model
`default_nettype wire

// ===== bench/error_record_status_test.sv
// Self-checking testbench of the error record status block.
`timescale 1ns/1ps
`default_nettype none

module error_record_status_test;
	localparam logic [63:0] ONES = 64'hffffffffffffffff;
	localparam logic [63:0] HIGH = 64'hffffffffffff0000;
	logic               clk, rst_b, reg_wr, reg_rd, reg_rvalid, rec_valid;
	logic               err_valid, err_poison, err_crit, err_snoop;
	logic [7:0]         reg_addr, err_code;
	logic [63:0]        reg_wdata, reg_rdata;
	logic [17:0]        err_index;
	logic [3:0]         err_way;
	ers_pkg::ers_kind_e err_kind;
	int                 n_errors = 0;
	int                 check_count = 0;

	ers_status_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
		.o_reg_rvalid(reg_rvalid), .i_err_valid(err_valid), .i_err_kind(err_kind),
		.i_err_poison(err_poison), .i_err_critical(err_crit), .i_err_snoop_ram(err_snoop),
		.i_err_code(err_code), .i_err_index(err_index), .i_err_way(err_way),
		.o_record_valid(rec_valid));
	ers_detector_model det (.i_clk(clk), .o_err_valid(err_valid), .o_err_kind(err_kind),
		.o_err_poison(err_poison), .o_err_critical(err_crit), .o_err_snoop_ram(err_snoop),
		.o_err_code(err_code), .o_err_index(err_index), .o_err_way(err_way));

	////////////////////////////////////////////////////////////////
	// Verdict and end of run.
	task automatic final_report();
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// Compare a value seen with the value expected.
	task automatic check(input string what, input logic [63:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	// One register write strobe.
	task automatic wr(input logic [7:0] a, input logic [63:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// One register read, compared under a mask; the answer wait is bounded.
	task automatic rd(input string what, input logic [7:0] a, input logic [63:0] exp, m);
		int n;
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 4) begin
			n_errors++;
			final_report();
		end
		check(what, reg_rdata & m, exp);
	endtask : rd

	////////////////////////////////////////////////////////////////
	// Empty record after reset; unused words ignore writes.
	task automatic t_reset();
		rd("status", 8'h10, 64'h0, ONES);
		rd("misc0", 8'h20, 64'h4, ONES);
		rd("unmapped", 8'h00, 64'h0, ONES);
		wr(8'h28, ONES);
		wr(8'h10, ONES);
		for (int i = 0; i < 3; i++)
			rd("misc spare", 8'h28 + 8'(i * 8), 64'h0, ONES);
		rd("status ones", 8'h10, 64'h0, ONES);
	endtask : t_reset

	// Uncorrected errors: first fills the record, second marks overflow.
	task automatic t_uncorr();
		det.raise(ers_pkg::ERS_KIND_UNCORRECTED, 1'b1, 1'b0, 1'b1, 8'h07, 18'h1, 4'h1);
		#1;
		check("valid pin", 64'(rec_valid), 64'h1);
		rd("status unc", 8'h10, 64'h64400207, ONES);
		det.raise(ers_pkg::ERS_KIND_UNCORRECTED, 1'b0, 1'b0, 1'b0, 8'h02, 18'h2, 4'h2);
		rd("status unc2", 8'h10, 64'h6c400207, ONES);
		wr(8'h10, ONES);
		rd("status clr", 8'h10, 64'h0, HIGH);
	endtask : t_uncorr

	// Corrected, repeat corrected, then deferred critical error.
	task automatic t_corr();
		det.raise(ers_pkg::ERS_KIND_CORRECTED, 1'b0, 1'b0, 1'b0, 8'h02, 18'h5, 4'h3);
		rd("status ce", 8'h10, 64'h46000002, ONES);
		det.raise(ers_pkg::ERS_KIND_CORRECTED, 1'b0, 1'b0, 1'b0, 8'h02, 18'h5, 4'h3);
		rd("status ce2", 8'h10, 64'h46000002, ONES);
		rd("misc0 rep", 8'h20, 64'h0000000230000144, ONES);
		det.raise(ers_pkg::ERS_KIND_DEFERRED, 1'b0, 1'b1, 1'b0, 8'h0c, 18'h9, 4'h1);
		rd("status def", 8'h10, 64'h4e88000c, ONES);
		wr(8'h10, 64'h0000000008000000);
		rd("status part", 8'h10, 64'h4688000c, ONES);
		wr(8'h10, ONES);
	endtask : t_corr

	// A counted corrected error wraps the counter and raises overflow.
	task automatic t_wrap();
		wr(8'h20, 64'h0000007f00000000);
		det.raise(ers_pkg::ERS_KIND_CORRECTED, 1'b0, 1'b0, 1'b0, 8'h16, 18'h5, 4'h3);
		rd("status wrap", 8'h10, 64'h4e000001, ONES);
		rd("misc0 wrap", 8'h20, 64'h0000008030000144, ONES);
		det.raise(ers_pkg::ERS_KIND_CORRECTED, 1'b0, 1'b0, 1'b0, 8'h16, 18'h6, 4'h3);
		rd("misc0 other", 8'h20, 64'h0000018030000144, ONES);
		rd("status other", 8'h10, 64'h4e000001, ONES);
	endtask : t_wrap

	// A reset in mid-run empties a dirty record and both counters.
	task automatic t_rerst();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd("status rst", 8'h10, 64'h0, ONES);
		rd("misc0 rst", 8'h20, 64'h4, ONES);
	endtask : t_rerst

	////////////////////////////////////////////////////////////////
	// Clock of 100 ns.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Reset, scenarios and verdict.
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 64'h0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_uncorr();
		t_corr();
		t_wrap();
		t_rerst();
		final_report();
	end
endmodule : error_record_status_test
`default_nettype wire
